// ### uamp_modem_model.sv
// far-side model: modem status lines and the 16x receive clock source
// assumes the bench sets carrier and ready levels after a clock edge
`timescale 1ns/1ns
module uamp_modem_model #(
	parameter int HALF = 4 // ref cycles per receive clock half period
) (
	input  wire logic clk,     // bench clock
	input  wire logic carrier, // carrier present request
	input  wire logic ready,   // data set ready request
	output logic      dcd_n,   // carrier detect pin, active low
	output logic      dsr_n,   // data set ready pin, active low
	output logic      rx_clk   // free-running 16x receive clock
);
	int   cnt   = 0;
	logic clk_q = 1'b0; // receive clock level

	// active-low modem lines follow the requested levels
	assign dcd_n  = ~carrier;
	assign dsr_n  = ~ready;
	assign rx_clk = clk_q;

	// receive clock toggles every HALF cycles, one rise per 2*HALF
	always @(posedge clk) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1)
			clk_q <= ~clk_q;
	end
endmodule

// ### uamp_modem_sync.sv
// two-stage synchroniser and change detector for the modem status pins
// assumes active-low pins that may change at any time
`timescale 1ns/1ns
module uamp_modem_sync (
	input  wire logic   clk,     // block clock
	input  wire logic   rst_n,   // synchronous reset, active low
	input  wire logic   dcd_n,   // carrier detect pin, active low
	input  wire logic   dsr_n,   // data set ready pin, active low
	uamp_msr_if.src     msr      // synchronised levels and changes
);
	logic [1:0] pin_n;
	logic [1:0] meta;   // first stage, read only by stab
	logic [1:0] stab;   // second stage
	logic [1:0] prev;   // last settled level

	assign pin_n = {dsr_n, dcd_n};

	// ----------------------------------------------------------------
	// per-pin synchroniser
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_pin
		// two flops, then a history flop for the edge compare
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				meta[g] <= uamp_pkg::PIN_IDLE;
				stab[g] <= uamp_pkg::PIN_IDLE;
				prev[g] <= uamp_pkg::PIN_IDLE;
			end else begin
				meta[g] <= pin_n[g];
				stab[g] <= meta[g];
				prev[g] <= stab[g];
			end
		end
	end

	// levels inverted to active high, one pulse per settled change
	assign msr.dcd     = ~stab[0];
	assign msr.dsr     = ~stab[1];
	assign msr.dcd_chg = stab[0] ^ prev[0]; // R15
	assign msr.dsr_chg = stab[1] ^ prev[1]; // R15
endmodule

// ### uamp_msr_if.sv
// carrier for synchronised modem levels and their change pulses
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface uamp_msr_if;
	logic dcd;     // carrier present, active high
	logic dsr;     // data set ready, active high
	logic dcd_chg; // one-cycle pulse on carrier change
	logic dsr_chg; // one-cycle pulse on ready change

	modport src (output dcd, output dsr, output dcd_chg, output dsr_chg);
	modport dst (input dcd, input dsr, input dcd_chg, input dsr_chg);
endinterface

// ### uamp_pkg.sv
// constants shared by the modem pin block and its input synchroniser
// assumes one 100 MHz clock and an AXI4-Lite register port with 32-bit data
package uamp_pkg;
	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_MCTL = 4'h0; // modem_control_reg
	localparam logic [3:0] OFS_MSR  = 4'h4; // modem status
	localparam logic [3:0] OFS_IST  = 4'h8; // sticky interrupt status
	localparam logic [3:0] OFS_IMSK = 4'hc; // interrupt mask

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned MCTL_DTR    = 0;
	localparam int unsigned MCTL_USER1  = 2;
	localparam int unsigned MCTL_USER2  = 3;
	localparam int unsigned MCTL_LOOP   = 4;
	localparam int unsigned MSR_DSR_CHG = 1;
	localparam int unsigned MSR_DCD_CHG = 3;
	localparam int unsigned MSR_DSR     = 5;
	localparam int unsigned MSR_DCD     = 7;
	localparam int unsigned INT_RX_ERR  = 0;
	localparam int unsigned INT_RX_DATA = 1;
	localparam int unsigned INT_THR     = 2;
	localparam int unsigned INT_MODEM   = 3;
	localparam int unsigned INT_N       = 4;

	// ----------------------------------------------------------------
	// reset values and bus answers
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_MCTL    = 8'h00;
	localparam logic [3:0] RST_MASK    = 4'h0;
	localparam logic [3:0] RST_IST     = 4'h0;
	localparam logic       PIN_IDLE    = 1'b1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// register select codes
	typedef enum logic [2:0] {
		SEL_MCTL = 3'h0,
		SEL_MSR  = 3'h1,
		SEL_IST  = 3'h2,
		SEL_IMSK = 3'h3,
		SEL_NONE = 3'h4
	} uamp_sel_t;
endpackage

// ### uamp_top.sv
// modem control and status pins, interrupt line and read-side pins
// assumes an AXI4-Lite master on REF_CLK and synchronous join signals
`timescale 1ns/1ns

// How it works
// [R01] MSR bit 7 shows the carrier level and bit 3 flags a carrier change.
// [R02] MSR bit 5 shows the data set ready level and bit 1 flags its change.
// [R03] both change flags record a change since the last MSR read, which clears them.
// [R04] with the modem interrupt unmasked, a carrier or ready change raises a request.
// [R05] the driver disable pin is high except while a CPU read is under way.
// [R06] the terminal ready pin goes low while its control bit is set.
// [R07] terminal ready stays high after master reset, in loop mode, and when cleared.
// [R08] the interrupt pin rises for receive error, receive data, empty transmitter or modem change.
// [R09] the interrupt pin falls once the pending cause is serviced, and on master reset.
// [R10] master reset held high clears the registers and parks every pin at rest; DRIVER_DISABLE_OUT, DATA_OE and DATA_OUT keep following the read path.
// [R11] user outputs one and two go low with control bits 2 and 3 and high when cleared.
// [R12] both user outputs stay high after master reset and in loop mode.
// [R13] the 16x receiver clock input paces the receiver through a tick pulse.
// [R14] eight data lines drive read data outward with an enable for the three-state buffer.
// [R15] modem inputs are synchronised before change detection so each change flags once.
module uamp_top (
	input  wire logic        REF_CLK,            // 100 MHz clock
	input  wire logic        NRST,               // synchronous reset, active low
	input  wire logic [3:0]  S_AXI_AWADDR,       // write address
	input  wire logic        S_AXI_AWVALID,      // write address valid
	output logic             S_AXI_AWREADY,      // write address ready
	input  wire logic [31:0] S_AXI_WDATA,        // write data
	input  wire logic [3:0]  S_AXI_WSTRB,        // write byte lanes
	input  wire logic        S_AXI_WVALID,       // write data valid
	output logic             S_AXI_WREADY,       // write data ready
	output logic [1:0]       S_AXI_BRESP,        // write response
	output logic             S_AXI_BVALID,       // write response valid
	input  wire logic        S_AXI_BREADY,       // write response ready
	input  wire logic [3:0]  S_AXI_ARADDR,       // read address
	input  wire logic        S_AXI_ARVALID,      // read address valid
	output logic             S_AXI_ARREADY,      // read address ready
	output logic [31:0]      S_AXI_RDATA,        // read data
	output logic [1:0]       S_AXI_RRESP,        // read response
	output logic             S_AXI_RVALID,       // read data valid
	input  wire logic        S_AXI_RREADY,       // read data ready
	input  wire logic        MASTER_RESET_IN,    // master reset, active high
	input  wire logic        DCD_N,              // carrier detect pin
	input  wire logic        DSR_N,              // data set ready pin
	output logic             DTR_N,              // terminal ready pin
	output logic             USER_OUT_ONE_N,     // user output one
	output logic             USER_OUT_TWO_N,     // user output two
	output logic             DRIVER_DISABLE_OUT, // transceiver disable
	output logic             INTERRUPT_OUT,      // interrupt request
	input  wire logic        RX_ERR_IN,          // receiver error level
	input  wire logic        RX_AVAIL_IN,        // received data available
	input  wire logic        RX_TIMEOUT_IN,      // receive timeout level
	input  wire logic        FIFO_MODE_IN,       // fifo mode selected
	input  wire logic        THR_EMPTY_IN,       // holding register empty
	input  wire logic        RECEIVER_CLOCK_IN,  // 16x receive clock
	output logic             RX_TICK_OUT,        // one pulse per rise
	input  wire logic [7:0]  DATA_IN,            // data lines, sensed
	output logic [7:0]       DATA_OUT,           // data lines, driven
	output logic             DATA_OE             // data lines enable
);
	// ----------------------------------------------------------------
	// decoding
	// ----------------------------------------------------------------

	// byte address to register select
	function automatic uamp_pkg::uamp_sel_t decode(input logic [3:0] addr);
		uamp_pkg::uamp_sel_t sel;
		case (addr)
			uamp_pkg::OFS_MCTL: sel = uamp_pkg::SEL_MCTL;
			uamp_pkg::OFS_MSR: sel = uamp_pkg::SEL_MSR;
			uamp_pkg::OFS_IST: sel = uamp_pkg::SEL_IST;
			uamp_pkg::OFS_IMSK: sel = uamp_pkg::SEL_IMSK;
			default: sel = uamp_pkg::SEL_NONE;
		endcase
		return sel;
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic                 aw_held;        // write address captured
	logic [3:0]           aw_addr;        // captured write address
	logic                 w_held;         // write data captured
	logic [7:0]           w_byte;         // captured low byte
	logic                 w_lane0;        // low lane enabled
	logic                 bvalid;         // write response pending
	logic [1:0]           bresp;          // write response code
	logic                 rvalid;         // read data pending
	logic [1:0]           rresp;          // read response code
	logic [31:0]          rdata;          // read data register
	logic [7:0]           mctl;           // modem_control_reg
	logic [3:0]           mask;           // interrupt mask
	logic [3:0]           ist;            // sticky interrupt status
	logic                 carrier_change_flag;
	logic                 dsr_change_flag;
	logic                 dtr_n;          // pin registers
	logic                 user1_n;
	logic                 user2_n;
	logic                 rclk_prev;      // last receive clock level
	logic                 rx_tick;        // receive clock rise pulse
	logic [7:0]           data_out;       // byte on the data lines

	wire                  rst_regs;       // either reset clears state
	wire                  do_write;       // both halves present
	wire                  ar_fire;        // read address taken
	wire                  wr_ok;          // write with low lane on
	uamp_pkg::uamp_sel_t  wr_sel;
	uamp_pkg::uamp_sel_t  rd_sel;
	wire                  msr_read;       // read of modem status
	wire                  ist_read;       // read of interrupt status
	wire [7:0]            msr_word;       // modem status image
	logic [31:0]          rd_word;        // selected read value
	wire                  loop_mode;
	wire [3:0]            int_event;      // raw interrupt causes
	wire [3:0]            int_clear;      // per-bit service clears
	wire                  next_dcd_flag;
	wire                  next_dsr_flag;

	uamp_msr_if msr ();

	// ----------------------------------------------------------------
	// modem input synchroniser
	// ----------------------------------------------------------------
	uamp_modem_sync u_sync (
		.clk   (REF_CLK),
		.rst_n (NRST),
		.dcd_n (DCD_N),
		.dsr_n (DSR_N),
		.msr   (msr.src)
	);

	// ----------------------------------------------------------------
	// bus decode and handshakes
	// ----------------------------------------------------------------
	assign rst_regs      = !NRST || MASTER_RESET_IN; // R10
	assign S_AXI_AWREADY = !aw_held && !bvalid;
	assign S_AXI_WREADY  = !w_held && !bvalid;
	assign S_AXI_ARREADY = !rvalid;
	assign do_write      = aw_held && w_held && !bvalid;
	assign ar_fire       = S_AXI_ARVALID && !rvalid;
	assign wr_sel        = decode(aw_addr);
	assign rd_sel        = decode(S_AXI_ARADDR);
	assign wr_ok         = do_write && w_lane0;
	assign msr_read      = ar_fire && (rd_sel == uamp_pkg::SEL_MSR);
	assign ist_read      = ar_fire && (rd_sel == uamp_pkg::SEL_IST);
	assign loop_mode     = mctl[uamp_pkg::MCTL_LOOP];

	// write address and data held until both are present
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 4'h0;
			w_byte  <= 8'h00;
			w_lane0 <= 1'b0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held  <= 1'b1;
				w_byte  <= S_AXI_WDATA[7:0];
				w_lane0 <= S_AXI_WSTRB[0];
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	// write response, error for an unmapped word
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			bvalid <= 1'b0;
			bresp  <= uamp_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= (wr_sel == uamp_pkg::SEL_NONE) ? uamp_pkg::RESP_SLVERR
				: uamp_pkg::RESP_OKAY;
		end else if (S_AXI_BREADY) begin
			bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	assign msr_word = {msr.dcd, 1'b0, msr.dsr, 1'b0,
		carrier_change_flag, 1'b0, dsr_change_flag, 1'b0}; // R01 R02

	// read value selection, unused bits zero
	always_comb begin
		case (rd_sel)
			uamp_pkg::SEL_MCTL: rd_word = {24'h000000, mctl};
			uamp_pkg::SEL_MSR: rd_word = {24'h000000, msr_word};
			uamp_pkg::SEL_IST: rd_word = {28'h0000000, ist};
			uamp_pkg::SEL_IMSK: rd_word = {28'h0000000, mask};
			default: rd_word = 32'h00000000;
		endcase
	end

	// read data held until the master takes it
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			rvalid   <= 1'b0;
			rresp    <= uamp_pkg::RESP_OKAY;
			rdata    <= 32'h00000000;
			data_out <= 8'h00;
		end else if (ar_fire) begin
			rvalid   <= 1'b1;
			rresp    <= (rd_sel == uamp_pkg::SEL_NONE) ? uamp_pkg::RESP_SLVERR
				: uamp_pkg::RESP_OKAY;
			rdata    <= rd_word;
			data_out <= rd_word[7:0]; // R14
		end else if (S_AXI_RREADY) begin
			rvalid <= 1'b0;
		end
	end

	assign S_AXI_BVALID       = bvalid;
	assign S_AXI_BRESP        = bresp;
	assign S_AXI_RVALID       = rvalid;
	assign S_AXI_RRESP        = rresp;
	assign S_AXI_RDATA        = rdata;
	assign DATA_OUT           = data_out;
	assign DATA_OE            = rvalid;  // R14
	assign DRIVER_DISABLE_OUT = !rvalid; // R05

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------

	// modem control and mask, cleared by either reset
	always_ff @(posedge REF_CLK) begin
		if (rst_regs) begin
			mctl <= uamp_pkg::RST_MCTL; // R10
			mask <= uamp_pkg::RST_MASK;
		end else if (wr_ok) begin
			if (wr_sel == uamp_pkg::SEL_MCTL) begin
				mctl <= w_byte;
			end
			if (wr_sel == uamp_pkg::SEL_IMSK) begin
				mask <= w_byte[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// modem change flags
	// ----------------------------------------------------------------
	assign next_dcd_flag = msr.dcd_chg || (carrier_change_flag && !msr_read); // R01 R03
	assign next_dsr_flag = msr.dsr_chg || (dsr_change_flag && !msr_read);     // R02 R03

	// a change in the read cycle survives the clear
	always_ff @(posedge REF_CLK) begin
		if (rst_regs) begin
			carrier_change_flag <= 1'b0;
			dsr_change_flag     <= 1'b0;
		end else begin
			carrier_change_flag <= next_dcd_flag;
			dsr_change_flag     <= next_dsr_flag;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status
	// ----------------------------------------------------------------
	assign int_event[uamp_pkg::INT_RX_ERR]  = RX_ERR_IN;                               // R08
	assign int_event[uamp_pkg::INT_RX_DATA] = RX_AVAIL_IN || (RX_TIMEOUT_IN && FIFO_MODE_IN); // R08
	assign int_event[uamp_pkg::INT_THR]     = THR_EMPTY_IN;                            // R08
	assign int_event[uamp_pkg::INT_MODEM]   = msr.dcd_chg || msr.dsr_chg;              // R04
	assign int_clear = {ist_read || msr_read, {3{ist_read}}};                          // R09

	// sticky bits, event wins over the read clear
	for (genvar g = 0; g < uamp_pkg::INT_N; g++) begin : g_ist
		always_ff @(posedge REF_CLK) begin
			if (rst_regs) begin
				ist[g] <= uamp_pkg::RST_IST[g];
			end else begin
				ist[g] <= int_event[g] || (ist[g] && !int_clear[g]);
			end
		end
	end

	assign INTERRUPT_OUT = |(ist & mask); // R08 R09

	// ----------------------------------------------------------------
	// modem and user output pins
	// ----------------------------------------------------------------

	// active low pins, parked high in reset and loop mode
	always_ff @(posedge REF_CLK) begin
		if (rst_regs) begin
			dtr_n   <= uamp_pkg::PIN_IDLE; // R07 R12
			user1_n <= uamp_pkg::PIN_IDLE;
			user2_n <= uamp_pkg::PIN_IDLE;
		end else begin
			dtr_n   <= !(mctl[uamp_pkg::MCTL_DTR] && !loop_mode);   // R06 R07
			user1_n <= !(mctl[uamp_pkg::MCTL_USER1] && !loop_mode); // R11 R12
			user2_n <= !(mctl[uamp_pkg::MCTL_USER2] && !loop_mode); // R11 R12
		end
	end

	assign DTR_N          = dtr_n;
	assign USER_OUT_ONE_N = user1_n;
	assign USER_OUT_TWO_N = user2_n;

	// ----------------------------------------------------------------
	// receive clock tick
	// ----------------------------------------------------------------

	// one pulse per rising edge of the 16x clock
	always_ff @(posedge REF_CLK) begin
		if (rst_regs) begin
			rclk_prev <= 1'b0;
			rx_tick   <= 1'b0;
		end else begin
			rclk_prev <= RECEIVER_CLOCK_IN;
			rx_tick   <= RECEIVER_CLOCK_IN && !rclk_prev; // R13
		end
	end

	assign RX_TICK_OUT = rx_tick;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!NRST);

	a_dcd_level_read: assert property ( // R01
		msr_read |=> (S_AXI_RDATA[7] == $past(msr.dcd)) && S_AXI_RVALID)
		else $error("carrier level misreported");

	a_dsr_level_read: assert property ( // R02
		msr_read |=> (S_AXI_RDATA[5] == $past(msr.dsr)))
		else $error("ready level misreported");

	a_flag_set_once: assert property ( // R15
		(msr.dcd_chg && !MASTER_RESET_IN) |=> carrier_change_flag ##1 !msr.dcd_chg)
		else $error("carrier change not flagged once");

	a_flag_read_clear: assert property ( // R03
		(msr_read && !msr.dcd_chg && !msr.dsr_chg)
		|=> !carrier_change_flag && !dsr_change_flag)
		else $error("change flags survived status read");

	a_modem_int_req: assert property ( // R04
		(msr.dsr_chg && mask[uamp_pkg::INT_MODEM] && !rst_regs && !wr_ok)
		|=> INTERRUPT_OUT)
		else $error("modem change raised no request");

	a_disable_during_read: assert property ( // R05
		ar_fire |=> !DRIVER_DISABLE_OUT [*1] ##0 (DATA_OE && DATA_OUT == $past(rd_word[7:0])))
		else $error("driver disable high during read");

	a_disable_idle_high: assert property ( // R05
		(!ar_fire && !S_AXI_RVALID) |=> DRIVER_DISABLE_OUT)
		else $error("driver disable low with no read");

	a_dtr_active: assert property ( // R06
		(mctl[uamp_pkg::MCTL_DTR] && !loop_mode && !rst_regs) ##1 !rst_regs |-> !DTR_N)
		else $error("terminal ready not driven low");

	a_dtr_parked: assert property ( // R07
		(rst_regs || loop_mode || !mctl[uamp_pkg::MCTL_DTR]) |=> DTR_N)
		else $error("terminal ready left low");

	a_user_out_level: assert property ( // R11
		(!rst_regs && !loop_mode) ##1 !rst_regs
		|-> (USER_OUT_ONE_N == !$past(mctl[uamp_pkg::MCTL_USER1]))
		&& (USER_OUT_TWO_N == !$past(mctl[uamp_pkg::MCTL_USER2])))
		else $error("user output does not follow control");

	a_user_out_park: assert property ( // R12
		(rst_regs || loop_mode) |=> USER_OUT_ONE_N && USER_OUT_TWO_N)
		else $error("user output not parked high");

	a_int_rx_error: assert property ( // R08
		(RX_ERR_IN && mask[uamp_pkg::INT_RX_ERR] && !rst_regs && !wr_ok) |=> INTERRUPT_OUT)
		else $error("receiver error raised no interrupt");

	a_int_reset_clear: assert property ( // R09 R10
		MASTER_RESET_IN |=> !INTERRUPT_OUT && (mctl == uamp_pkg::RST_MCTL))
		else $error("master reset left state behind");

	a_rx_tick_pulse: assert property ( // R13
		$rose(RECEIVER_CLOCK_IN) && !rst_regs |=> RX_TICK_OUT ##1 !RX_TICK_OUT)
		else $error("receive tick missing or long");
endmodule

// ### uamp_top_tb.sv
// self-checking bench for the modem pin block
// assumes the modem model on the status pins and AXI4-Lite driven here
`timescale 1ns/1ns
module uamp_top_tb;
	logic REF_CLK = 1'b0, NRST = 1'b0, MASTER_RESET_IN = 1'b0;
	logic [3:0] S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'hf;
	logic [31:0] S_AXI_WDATA = 32'h0;
	logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
	logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, THR_EMPTY_IN = 1'b0;
	logic RX_ERR_IN = 1'b0, RX_AVAIL_IN = 1'b0, RX_TIMEOUT_IN = 1'b0, FIFO_MODE_IN = 1'b0;
	logic carrier = 1'b0, ready = 1'b0;
	logic [7:0] DATA_IN = 8'h00;
	logic DCD_N, DSR_N, RECEIVER_CLOCK_IN, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
	logic S_AXI_ARREADY, S_AXI_RVALID, DTR_N, USER_OUT_ONE_N, USER_OUT_TWO_N;
	logic DRIVER_DISABLE_OUT, INTERRUPT_OUT, RX_TICK_OUT, DATA_OE;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic [31:0] S_AXI_RDATA;
	logic [7:0] DATA_OUT, d;
	int n_mismatch = 0, n_tests = 0;

	uamp_top uut (.*);
	uamp_modem_model model (.clk(REF_CLK), .carrier(carrier), .ready(ready),
		.dcd_n(DCD_N), .dsr_n(DSR_N), .rx_clk(RECEIVER_CLOCK_IN));

	// 100 MHz clock
	always #5 REF_CLK = ~REF_CLK;

	task wrap_up;
		$display("mismatches %0d of %0d checks", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task tmo(input int i);
		if (i >= 50) begin
			n_mismatch++;
			wrap_up;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask
	// write one byte, address and data offered together
	task wr(input logic [3:0] a, input logic [7:0] v);
		int i;
		logic pa, pw, ta, tw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge REF_CLK);
		{S_AXI_AWADDR, S_AXI_WDATA} <= {a, 24'h0, v};
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
		for (i = 0; i < 50 && (pa || pw); i++) begin
			@(negedge REF_CLK);
			ta = pa && S_AXI_AWREADY;
			tw = pw && S_AXI_WREADY;
			@(posedge REF_CLK);
			if (ta) begin
				pa = 1'b0;
				S_AXI_AWVALID <= 1'b0;
			end
			if (tw) begin
				pw = 1'b0;
				S_AXI_WVALID <= 1'b0;
			end
		end
		tmo(i);
		for (i = 0; i < 50 && !S_AXI_BVALID; i++)
			@(negedge REF_CLK);
		tmo(i);
		chk("bresp", 8'h00, {6'h0, S_AXI_BRESP});
		@(posedge REF_CLK);
		S_AXI_BREADY <= 1'b0;
	endtask
	// read one byte; the data lines and disable pin are judged meanwhile
	task rd(input logic [3:0] a, output logic [7:0] v);
		int i;
		logic [1:0] er;
		er = (a[1:0] != 2'h0) ? uamp_pkg::RESP_SLVERR : uamp_pkg::RESP_OKAY;
		@(posedge REF_CLK);
		S_AXI_ARADDR <= a;
		{S_AXI_ARVALID, S_AXI_RREADY} <= 2'b11;
		for (i = 0; i < 50; i++) begin
			@(negedge REF_CLK);
			if (S_AXI_ARREADY)
				break;
		end
		tmo(i);
		@(posedge REF_CLK);
		S_AXI_ARVALID <= 1'b0;
		for (i = 0; i < 50 && !S_AXI_RVALID; i++)
			@(negedge REF_CLK);
		tmo(i);
		v = S_AXI_RDATA[7:0];
		chk("disable", 8'h00, {7'h0, DRIVER_DISABLE_OUT});
		chk("oe", 8'h01, {7'h0, DATA_OE});
		chk("data", v, DATA_OUT);
		chk("rresp", {6'h0, er}, {6'h0, S_AXI_RRESP});
		@(posedge REF_CLK);
		S_AXI_RREADY <= 1'b0;
	endtask
	task mreset;
		@(posedge REF_CLK);
		MASTER_RESET_IN <= 1'b1;
		@(posedge REF_CLK);
		MASTER_RESET_IN <= 1'b0;
		cyc(3);
	endtask
	task t_pins;
		chk("rest", 8'h0f, {DTR_N, USER_OUT_ONE_N, USER_OUT_TWO_N, DRIVER_DISABLE_OUT});
		rd(4'h2, d);
		chk("unmapped", 8'h00, d);
		wr(4'h0, 8'h0d);
		cyc(3);
		chk("on", 8'h00, {DTR_N, USER_OUT_ONE_N, USER_OUT_TWO_N});
		wr(4'h0, 8'h1d);
		cyc(3);
		chk("loop", 8'h07, {DTR_N, USER_OUT_ONE_N, USER_OUT_TWO_N});
		wr(4'h0, 8'h04);
		cyc(3);
		chk("one", 8'h05, {DTR_N, USER_OUT_ONE_N, USER_OUT_TWO_N});
		wr(4'h0, 8'h09);
		mreset;
		chk("reset pins", 8'h07, {DTR_N, USER_OUT_ONE_N, USER_OUT_TWO_N});
	endtask
	task t_modem;
		wr(4'hc, 8'h08);
		carrier <= 1'b1;
		cyc(6);
		chk("irq", 8'h01, {7'h0, INTERRUPT_OUT});
		rd(4'h4, d);
		chk("msr", 8'h88, d);
		rd(4'h4, d);
		chk("msr", 8'h80, d);
		chk("irq", 8'h00, {7'h0, INTERRUPT_OUT});
		ready <= 1'b1;
		cyc(6);
		rd(4'h4, d);
		chk("msr", 8'ha2, d);
		{carrier, ready} <= 2'b00;
		cyc(6);
		rd(4'h4, d);
		chk("msr", 8'h0a, d);
	endtask
	// each non-modem interrupt source in turn, then master reset and masking
	task t_irq;
		wr(4'hc, 8'h0f);
		for (int k = 0; k < 4; k++) begin
			{RX_ERR_IN, RX_AVAIL_IN, THR_EMPTY_IN} <= {k == 0, k == 1, k == 2};
			{RX_TIMEOUT_IN, FIFO_MODE_IN} <= {k == 3, k == 3};
			cyc(3);
			chk("irq", 8'h01, {7'h0, INTERRUPT_OUT});
			{RX_ERR_IN, RX_AVAIL_IN, THR_EMPTY_IN, RX_TIMEOUT_IN} <= 4'h0;
			cyc(3);
			rd(4'h8, d);
			chk("ist", (k == 2) ? 8'h04 : (k == 0) ? 8'h01 : 8'h02, d);
			chk("irq", 8'h00, {7'h0, INTERRUPT_OUT});
		end
		RX_ERR_IN <= 1'b1;
		cyc(2);
		RX_ERR_IN <= 1'b0;
		mreset;
		chk("irq", 8'h00, {7'h0, INTERRUPT_OUT});
		THR_EMPTY_IN <= 1'b1;
		cyc(3);
		chk("mask", 8'h00, {7'h0, INTERRUPT_OUT});
		THR_EMPTY_IN <= 1'b0;
	endtask
	task t_tick;
		int n;
		n = 0;
		repeat (80) begin
			@(negedge REF_CLK);
			n += RX_TICK_OUT;
		end
		chk("ticks", 8'd10, n[7:0]);
	endtask

	// reset for 4 cycles, then the scenarios
	initial begin
		repeat (4) @(posedge REF_CLK);
		NRST <= 1'b1;
		cyc(4);
		t_pins;
		t_modem;
		t_irq;
		t_tick;
		wrap_up;
	end
endmodule
